// File: core/bit_unit_pkg.sv
/*
  Package for the single-bit manipulation datapath: operation codes,
  operand widths and the request and answer structs.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package bit_unit_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BITNO_W = 3;
  localparam int unsigned GREG_W = 8;
  localparam logic [BITNO_W-1:0] BITNO_RST = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // Operation selector, the carry-combining group listed together.
  typedef enum logic [2:0] {
    bit_invert_op,
    bit_test_op,
    carry_and_bit_op,
    carry_and_inv_bit_op,
    carry_or_bit_op,
    carry_or_inv_bit_op,
    carry_xor_bit_op
  } bit_op_e;

  // One request: operation, operand, and the two possible bit-number sources.
  typedef struct packed {
    bit_op_e op;
    logic [BYTE_W-1:0] operand;
    logic [BITNO_W-1:0] imm_bitno;
    logic [GREG_W-1:0] reg_bitno;
    logic use_reg_bitno;
    logic carry_in;
  } bit_req_s;

  // One answer, registered.
  typedef struct packed {
    logic [BYTE_W-1:0] result;
    logic write_operand;
    logic zero_flag;
    logic write_zero;
    logic carry_flag;
    logic write_carry;
    logic bad_bitno_src;
  } bit_rsp_s;

endpackage

// File: core/bit_select.sv
/*
  Bit picker: returns the selected bit of a byte and the byte with that
  bit complemented.
  Assumes a bit number already reduced to three bits by the caller.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_select #(
  parameter int unsigned W = 8,
  parameter int unsigned N = 3
) (
  input wire logic [W-1:0] value,
  input wire logic [N-1:0] bitno,
  output logic picked,
  output logic [W-1:0] flipped
);

  // Only the chosen position changes, so the other bits pass untouched.
  always_comb begin
    picked = value[bitno];
    flipped = value ^ (W'(1) << bitno);
  end

endmodule
`default_nettype wire

// File: core/bit_manipulation_unit.sv
/*
  Single-bit instruction datapath: invert, test, and carry-combine one bit
  of a byte operand, result registered one cycle after a valid request.
  The answer carries write strobes for the operand, the zero flag and the
  carry flag; a consumer commits only the fields whose strobe is high.
  Assumes operand fetch and write-back happen outside, on the same clock,
  and that the request inputs come from logic clocked by mclk, so they
  need no synchronising flip-flops.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_manipulation_unit (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire bit_unit_pkg::bit_req_s req,
  output logic rsp_valid,
  output bit_unit_pkg::bit_rsp_s rsp
);

  // Working nets: the chosen bit number, the op class and the picker's outputs.
  logic [bit_unit_pkg::BITNO_W-1:0] bitno;
  logic is_carry_op;
  logic picked;
  logic [bit_unit_pkg::BYTE_W-1:0] flipped;
  bit_unit_pkg::bit_rsp_s rsp_d;
  bit_unit_pkg::bit_rsp_s rsp_q;
  logic rsp_valid_q;

  // Carry operations ignore the register source entirely.
  // A register number offered with a carry op is a decode fault upstream; it
  // is flagged in the answer rather than obeyed, so the carry result still
  // follows the immediate field.
  always_comb begin
    is_carry_op = !(req.op == bit_unit_pkg::bit_invert_op || req.op == bit_unit_pkg::bit_test_op);
    if (req.use_reg_bitno && !is_carry_op) begin
      bitno = req.reg_bitno[bit_unit_pkg::BITNO_W-1:0];
    end else begin
      bitno = req.imm_bitno;
    end
  end

  // One picker serves every operation; only the bit-number source differs,
  // which keeps the invert and the test paths from drifting apart.
  bit_select #(
    .W(bit_unit_pkg::BYTE_W),
    .N(bit_unit_pkg::BITNO_W)
  ) u_pick (
    .value(req.operand),
    .bitno(bitno),
    .picked(picked),
    .flipped(flipped)
  );

  // Next answer; the result and carry fields, when not written, hold harmless copies so that a
  // consumer that ignores the write strobes still sees the old operand.
  always_comb begin
    rsp_d = '0;
    rsp_d.result = req.operand;
    rsp_d.carry_flag = req.carry_in;
    rsp_d.bad_bitno_src = is_carry_op && req.use_reg_bitno;
    case (req.op)
      bit_unit_pkg::bit_invert_op: begin
        rsp_d.result = flipped;
        rsp_d.write_operand = 1'b1;
      end
      bit_unit_pkg::bit_test_op: begin
        rsp_d.zero_flag = !picked;
        rsp_d.write_zero = 1'b1;
      end
      bit_unit_pkg::carry_and_bit_op: begin
        rsp_d.carry_flag = req.carry_in & picked;
        rsp_d.write_carry = 1'b1;
      end
      bit_unit_pkg::carry_and_inv_bit_op: begin
        rsp_d.carry_flag = req.carry_in & !picked;
        rsp_d.write_carry = 1'b1;
      end
      bit_unit_pkg::carry_or_bit_op: begin
        rsp_d.carry_flag = req.carry_in | picked;
        rsp_d.write_carry = 1'b1;
      end
      bit_unit_pkg::carry_or_inv_bit_op: begin
        rsp_d.carry_flag = req.carry_in | !picked;
        rsp_d.write_carry = 1'b1;
      end
      bit_unit_pkg::carry_xor_bit_op: begin
        rsp_d.carry_flag = req.carry_in ^ picked;
        rsp_d.write_carry = 1'b1;
      end
      default: begin
        // The unused eighth code writes nothing, so a stray decode is harmless.
        rsp_d.write_carry = 1'b0;
      end
    endcase
  end

  // Answer register, loaded only on a valid request.
  // Holding it between requests lets a slow consumer read the answer late.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rsp_q <= '0;
    end else if (req_valid) begin
      rsp_q <= rsp_d;
    end
  end

  // Valid strobe, one cycle per accepted request.
  // A request presented during reset is dropped, not queued.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid;
    end
  end

  // Outputs straight from the registers, so no decode glitch reaches the consumer.
  assign rsp = rsp_q;
  assign rsp_valid = rsp_valid_q;

  // Invert: exactly one bit changes, at the chosen place, and only the operand is written.
  a_invert_one_bit: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_invert_op |=> rsp.write_operand
      && $countones(rsp.result ^ $past(req.operand)) == 1) else $error("invert changed wrong bit count");
  a_invert_position: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_invert_op && !req.use_reg_bitno
      |=> rsp.result[$past(req.imm_bitno)] != $past(req.operand[req.imm_bitno]))
    else $error("invert hit wrong position");
  a_invert_reg_position: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_invert_op && req.use_reg_bitno
      |=> rsp.result[$past(req.reg_bitno[2:0])] != $past(req.operand[req.reg_bitno[2:0]]))
    else $error("invert hit wrong register position");
  a_invert_strobes: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_invert_op
      |=> !rsp.write_zero && !rsp.write_carry && !rsp.bad_bitno_src)
    else $error("invert raised a flag strobe");

  // Test: the zero flag is the inverse of the chosen bit, from either bit-number source.
  a_reg_low_bits: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_test_op && req.use_reg_bitno
      |=> rsp.zero_flag == !$past(req.operand[req.reg_bitno[2:0]]))
    else $error("register bit number misused");
  a_test_imm_zero: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_test_op && !req.use_reg_bitno
      |=> rsp.zero_flag == !$past(req.operand[req.imm_bitno]))
    else $error("test zero flag wrong");
  a_test_zero: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::bit_test_op |=> rsp.write_zero && !rsp.write_operand
      && !rsp.write_carry && rsp.result == $past(req.operand)) else $error("test wrong or modified operand");
  a_zero_only_test: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op != bit_unit_pkg::bit_test_op |=> !rsp.zero_flag && !rsp.write_zero)
    else $error("zero flag touched by another op");

  // Carry combining: each result is checked against its own formula, always with the
  // immediate bit number, even when a register number is offered alongside it.
  a_carry_and: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::carry_and_bit_op
      |=> rsp.carry_flag == ($past(req.carry_in) & $past(req.operand[req.imm_bitno])))
    else $error("carry and wrong");
  a_carry_andn: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::carry_and_inv_bit_op
      |=> rsp.carry_flag == ($past(req.carry_in) & !$past(req.operand[req.imm_bitno])))
    else $error("carry and inverted wrong");
  a_carry_or: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::carry_or_bit_op
      |=> rsp.carry_flag == ($past(req.carry_in) | $past(req.operand[req.imm_bitno])))
    else $error("carry or wrong");
  a_carry_orn: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::carry_or_inv_bit_op
      |=> rsp.carry_flag == ($past(req.carry_in) | !$past(req.operand[req.imm_bitno])))
    else $error("carry or inverted wrong");
  a_carry_xor: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op == bit_unit_pkg::carry_xor_bit_op
      |=> rsp.carry_flag == ($past(req.carry_in) ^ $past(req.operand[req.imm_bitno])))
    else $error("carry xor wrong");
  a_carry_keeps_op: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req.op != bit_unit_pkg::bit_invert_op && req.op != bit_unit_pkg::bit_test_op
      |=> rsp.write_carry && !rsp.write_operand && !rsp.write_zero && rsp.result == $past(req.operand))
    else $error("carry op touched operand");
  a_bad_src_flag: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid |=> rsp.bad_bitno_src == ($past(req.use_reg_bitno)
      && $past(req.op) != bit_unit_pkg::bit_invert_op && $past(req.op) != bit_unit_pkg::bit_test_op))
    else $error("bad bit-number source flag wrong");

  // Handshake: one strobe per taken request, and the answer holds between requests
  // so that a slow consumer may still read it.
  a_valid_follows: assert property (@(posedge mclk) disable iff (!nrst) // Strobe follows a request.
    req_valid |=> rsp_valid)
    else $error("valid strobe missing");
  a_valid_idle: assert property (@(posedge mclk) disable iff (!nrst) // No strobe without a request.
    !req_valid |=> !rsp_valid)
    else $error("valid strobe without request");
  a_rsp_holds: assert property (@(posedge mclk) disable iff (!nrst) // Answer holds when idle.
    !req_valid |=> $stable(rsp))
    else $error("answer changed without request");
  a_carry_echo: assert property (@(posedge mclk) disable iff (!nrst) // Carry left alone.
    req_valid && (req.op == bit_unit_pkg::bit_invert_op || req.op == bit_unit_pkg::bit_test_op)
      |=> !rsp.write_carry && rsp.carry_flag == $past(req.carry_in))
    else $error("non-carry op wrote the carry");

  // Reset clears the strobe and the whole answer, whatever the request inputs show.
  a_reset_quiet: assert property (@(posedge mclk) // Reset state.
    !nrst |=> !rsp_valid && rsp == '0)
    else $error("answer not cleared by reset");

endmodule
`default_nettype wire

// File: testbench/testbench.sv
/*
  Self-checking bench for the single-bit datapath: invert, test and carry ops.
  Assumes the core package and unit are compiled first, one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  bit_unit_pkg::bit_req_s req = '0;
  logic rsp_valid;
  bit_unit_pkg::bit_rsp_s rsp;
  int num_errors = 0;
  int check_count = 0;

  bit_manipulation_unit u_bit_manipulation_unit (
    .mclk(mclk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req(req),
    .rsp_valid(rsp_valid),
    .rsp(rsp)
  );

  // A 20 ns half period gives the 25 MHz core clock.
  always #20 mclk = ~mclk;

  // Byte and bit comparisons; case inequality so an unknown never matches.
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  // One request, issued 1 ns after an edge and taken at the next; the strobe is read
  // 1 ns later, then an idle edge passes so the strobe never drops and rises at once.
  task automatic issue(input bit_unit_pkg::bit_op_e op, input logic [7:0] opnd, input logic [2:0] imm,
                       input logic [7:0] regno, input logic use_reg, input logic cin);
    req = '{op: op, operand: opnd, imm_bitno: imm, reg_bitno: regno, use_reg_bitno: use_reg, carry_in: cin};
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    cmp1(rsp_valid, 1'b1);
    @(posedge mclk);
    #1;
    cmp1(rsp_valid, 1'b0);
  endtask

  // Register numbers carry junk in the high bits, and the immediate is wrong on purpose.
  task automatic t_invert;
    for (int b = 0; b < 8; b++) begin
      issue(bit_unit_pkg::bit_invert_op, 8'hA5, 3'(b), 8'h00, 1'b0, 1'b0);
      cmp8(rsp.result, 8'hA5 ^ (8'h01 << b));
      cmp1(rsp.write_operand, 1'b1);
      cmp1(rsp.write_carry, 1'b0);
      issue(bit_unit_pkg::bit_invert_op, 8'h3C, 3'(7 - b), {5'h1F, 3'(b)}, 1'b1, 1'b0);
      cmp8(rsp.result, 8'h3C ^ (8'h01 << b));
      cmp1(rsp.bad_bitno_src, 1'b0);
    end
    $display("test invert done");
  endtask

  task automatic t_test;
    logic [7:0] v;
    v = 8'h5A;
    for (int b = 0; b < 8; b++) begin
      issue(bit_unit_pkg::bit_test_op, v, 3'(b), 8'h00, 1'b0, 1'b0);
      cmp1(rsp.zero_flag, ~v[b]);
      cmp1(rsp.write_zero, 1'b1);
      cmp8(rsp.result, v);
      cmp1(rsp.write_operand, 1'b0);
      issue(bit_unit_pkg::bit_test_op, ~v, 3'(7 - b), {5'h15, 3'(b)}, 1'b1, 1'b0);
      cmp1(rsp.zero_flag, v[b]);
    end
    $display("test bit test done");
  endtask

  // Odd positions also offer a register bit number, which must be ignored.
  task automatic t_carry;
    logic [7:0] v;
    logic x;
    logic e;
    bit_unit_pkg::bit_op_e ops [5];
    v = 8'h96;
    ops = '{bit_unit_pkg::carry_and_bit_op, bit_unit_pkg::carry_and_inv_bit_op, bit_unit_pkg::carry_or_bit_op,
            bit_unit_pkg::carry_or_inv_bit_op, bit_unit_pkg::carry_xor_bit_op};
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < 2; c++) begin
        for (int b = 0; b < 8; b++) begin
          x = v[b];
          e = (k == 0) ? (c[0] & x) : (k == 1) ? (c[0] & ~x) : (k == 2) ? (c[0] | x) :
              (k == 3) ? (c[0] | ~x) : (c[0] ^ x);
          issue(ops[k], v, 3'(b), {5'h00, 3'(~b)}, b[0], c[0]);
          cmp1(rsp.carry_flag, e);
          cmp1(rsp.write_carry, 1'b1);
          cmp1(rsp.write_operand, 1'b0);
          cmp8(rsp.result, v);
          cmp1(rsp.bad_bitno_src, b[0]);
        end
      end
    end
    $display("test carry ops done");
  endtask

  // Reset in mid-run with a request pending, then a fresh request once it is released.
  task automatic t_reset;
    issue(bit_unit_pkg::carry_or_bit_op, 8'hFF, 3'h0, 8'h00, 1'b0, 1'b1);
    cmp1(rsp.carry_flag, 1'b1);
    nrst = 1'b0;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    req_valid = 1'b0;
    cmp1(rsp_valid, 1'b0);
    cmp8(rsp.result, 8'h00);
    cmp1(rsp.carry_flag, 1'b0);
    @(posedge mclk);
    #1;
    cmp1(rsp_valid, 1'b0);
    cmp8(rsp.result, 8'h00);
    issue(bit_unit_pkg::bit_invert_op, 8'h00, 3'h3, 8'h00, 1'b0, 1'b0);
    cmp8(rsp.result, 8'h08);
    $display("test reset done");
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset for two edges, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    cmp1(rsp_valid, 1'b0);
    cmp8(rsp.result, 8'h00);
    t_invert();
    t_test();
    t_carry();
    t_reset();
    finish_test();
  end

  // About 115 requests of two cycles each; 2500 cycles leaves ample margin.
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
